// >>> design/ipb_identify_block.sv
// Function
// - words 7-8 give total sectors, the first out-of-range block address
// - serial number in words 10-19, right aligned, padded with 20h
// - model number in words 27-46, left aligned, padded with 20h
// - word 47 gives the largest sectors per interrupt for multiple commands
// - word 49 bit 13 reads zero
// - word 49 bit 11 iordy supported, bit 10 iordy can be disabled
// - word 49 bit 9 lba supported, bit 8 dma supported
// - word 51 upper byte reads 02h
// - word 53 bits 0, 1 and 2 read one
// - words 54-56 current geometry, 57-58 their product; 3 and 6 defaults
// - word 59: bit 8 one, upper bits zero, low byte zero or one
// - words 60-61 give total sectors addressable by lba
// - word 63 upper byte one-hot selected multiword dma mode
// - word 63 lower byte lists supported multiword dma modes
// - word 64 bit 1 pio mode 4, bit 0 pio mode 3
// - word 65 never below the fastest supported dma mode cycle
// - word 66 never below word 65
// - word 67 at least word 68 when pio mode 3 or above
// - word 68 equals the fastest supported pio mode cycle
// - unsupported cycle-time fields read zero
// - word 76 reports serial link capabilities, bit 0 zero
// - word 78 reports serial link features, bit 0 zero
// - word 0 reads 045ah, non-removable
`timescale 1ns/1ps
`include "ipb_params.svh"

module ipb_identify_block (
  input  wire logic        clock,        // core clock, 40 mhz
  input  wire logic        rst,          // synchronous reset, active high
  input  wire logic        wordReqValid, // word read request
  input  wire logic [7:0]  wordReqIndex, // identify word number
  output logic             wordValid,    // answer pulse
  output logic [15:0]      wordData,     // answered word
  input  wire logic [7:0]  s_axi_awaddr, // write address
  input  wire logic        s_axi_awvalid,// write address valid
  output logic             s_axi_awready,// write address ready
  input  wire logic [31:0] s_axi_wdata,  // write data
  input  wire logic [3:0]  s_axi_wstrb,  // write byte strobes
  input  wire logic        s_axi_wvalid, // write data valid
  output logic             s_axi_wready, // write data ready
  output logic [1:0]       s_axi_bresp,  // write response
  output logic             s_axi_bvalid, // write response valid
  input  wire logic        s_axi_bready, // write response ready
  input  wire logic [7:0]  s_axi_araddr, // read address
  input  wire logic        s_axi_arvalid,// read address valid
  output logic             s_axi_arready,// read address ready
  output logic [31:0]      s_axi_rdata,  // read data
  output logic [1:0]       s_axi_rresp,  // read response
  output logic             s_axi_rvalid, // read data valid
  input  wire logic        s_axi_rready  // read data ready
);

  logic [31:0]       totalSec_r;
  logic [15:0]       defCyl_r;
  logic [15:0]       defHeads_r;
  logic [15:0]       defSpt_r;
  logic [7:0]        maxMult_r;
  logic [15:0]       curCyl_r;
  logic [15:0]       curHeads_r;
  logic [15:0]       curSpt_r;
  logic [7:0]        mult_r;
  logic [3:0]        cap_r;
  logic [2:0]        mdmaSup_r;
  ipb_pkg::ipb_mdma_e mdmaSel_r;
  logic [1:0]        pioSup_r;
  logic [15:0]       dmaMin_r;
  logic [15:0]       dmaRec_r;
  logic [15:0]       pioNoFc_r;
  logic [10:0]       sataCap_r;
  logic [6:0]        sataFeat_r;
  logic [4:0]        serLen_r;
  logic [5:0]        modLen_r;
  logic [7:0]        winIdx_r;
  logic [15:0]       reqCount_r;
  ipb_pkg::ipb_char_t serChars [20];
  ipb_pkg::ipb_char_t modChars [40];

  logic              awHeld_r;
  logic              wHeld_r;
  logic [7:0]        awAddr_r;
  logic [31:0]       wData_r;
  logic [3:0]        wStrb_r;
  logic              wrEn;
  logic [47:0]       capProd;
  logic [15:0]       dmaFloor;
  logic [15:0]       w65;
  logic [15:0]       w66;
  logic [15:0]       w67;
  logic [15:0]       w68;
  logic [7:0]        mdmaOneHot;

  function automatic logic [31:0] strbMerge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic wrHit(input logic [7:0] off);
    return wrEn && (awAddr_r == off);
  endfunction

  // serial text sits at the right end of its field
  function automatic ipb_pkg::ipb_char_t serChar(input logic [4:0] p);
    logic [4:0] pad;
    logic [4:0] src;
    pad = `IPB_SER_LEN - serLen_r;
    src = p - pad;
    if (p < pad) begin
      return `IPB_PAD_CHAR;
    end
    return serChars[src];
  endfunction

  // model text sits at the left end of its field
  function automatic ipb_pkg::ipb_char_t modChar(input logic [5:0] p);
    if (p >= modLen_r) begin
      return `IPB_PAD_CHAR;
    end
    return modChars[p];
  endfunction

  function automatic ipb_pkg::ipb_word_t identWord(input logic [7:0] idx);
    logic [7:0] k;
    ipb_pkg::ipb_word_t w;
    k = 8'h00;
    w = 16'h0000;
    if (idx >= 8'd10 && idx <= 8'd19) begin
      k = idx - 8'd10;
      w = {serChar({k[3:0], 1'b0}), serChar({k[3:0], 1'b1})};
    end else if (idx >= 8'd27 && idx <= 8'd46) begin
      k = idx - 8'd27;
      w = {modChar({k[4:0], 1'b0}), modChar({k[4:0], 1'b1})};
    end else begin
      unique case (idx)
        8'd0:  w = `IPB_WORD0_VAL;
        8'd1:  w = defCyl_r;
        8'd3:  w = defHeads_r;
        8'd6:  w = defSpt_r;
        8'd7:  w = totalSec_r[15:0];
        8'd8:  w = totalSec_r[31:16];
        8'd47: w = {`IPB_WORD47_HI, maxMult_r};
        8'd49: w = {4'h0, cap_r, 8'h00};
        8'd50: w = `IPB_WORD50_VAL;
        8'd51: w = `IPB_WORD51_VAL;
        8'd53: w = `IPB_WORD53_VAL;
        8'd54: w = curCyl_r;
        8'd55: w = curHeads_r;
        8'd56: w = curSpt_r;
        8'd57: w = capProd[15:0];
        8'd58: w = capProd[31:16];
        8'd59: w = {7'h00, 1'b1, mult_r};
        8'd60: w = totalSec_r[15:0];
        8'd61: w = totalSec_r[31:16];
        8'd63: w = {mdmaOneHot, 5'h00, mdmaSup_r};
        8'd64: w = {14'h0000, pioSup_r};
        8'd65: w = w65;
        8'd66: w = w66;
        8'd67: w = w67;
        8'd68: w = w68;
        8'd76: w = {5'h00, sataCap_r};
        8'd78: w = {9'h000, sataFeat_r};
        default: w = 16'h0000;
      endcase
    end
    return w;
  endfunction

  // ---------------- derived identify fields
  assign capProd = 48'(curCyl_r) * 48'(curHeads_r) * 48'(curSpt_r);

  always_comb begin
    unique case (mdmaSel_r)
      ipb_pkg::IPB_MDMA_0: mdmaOneHot = 8'h01;
      ipb_pkg::IPB_MDMA_1: mdmaOneHot = 8'h02;
      ipb_pkg::IPB_MDMA_2: mdmaOneHot = 8'h04;
      ipb_pkg::IPB_MDMA_NONE: mdmaOneHot = 8'h00;
    endcase
  end

  always_comb begin
    if (mdmaSup_r[2]) begin
      dmaFloor = `IPB_MDMA2_NS;
    end else if (mdmaSup_r[1]) begin
      dmaFloor = `IPB_MDMA1_NS;
    end else begin
      dmaFloor = `IPB_MDMA0_NS;
    end
  end

  always_comb begin
    if (mdmaSup_r == 3'h0) begin
      w65 = 16'h0000;
      w66 = 16'h0000;
    end else begin
      w65 = (dmaMin_r < dmaFloor) ? dmaFloor : dmaMin_r;
      w66 = (dmaRec_r < w65) ? w65 : dmaRec_r;
    end
    if (pioSup_r == 2'h0) begin
      w68 = 16'h0000;
      w67 = 16'h0000;
    end else begin
      w68 = pioSup_r[1] ? `IPB_PIO4_NS : `IPB_PIO3_NS;
      w67 = (pioNoFc_r < w68) ? w68 : pioNoFc_r;
    end
  end

  // ---------------- word port
  always_ff @(posedge clock) begin
    if (rst) begin
      wordValid  <= 1'b0;
      wordData   <= 16'h0000;
      reqCount_r <= 16'h0000;
    end else begin
      wordValid <= wordReqValid;
      if (wordReqValid) begin
        wordData   <= identWord(wordReqIndex);
        reqCount_r <= reqCount_r + 16'h0001;
      end
    end
  end

  // ---------------- axi4-lite write channels
  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready  = !wHeld_r;
  assign wrEn          = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign s_axi_bresp   = 2'h0;

  always_ff @(posedge clock) begin
    if (rst) begin
      awHeld_r     <= 1'b0;
      wHeld_r      <= 1'b0;
      awAddr_r     <= 8'h00;
      wData_r      <= 32'h0000_0000;
      wStrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && !awHeld_r) begin
        awHeld_r <= 1'b1;
        awAddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wrEn) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld_r) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (wrEn) begin
        wHeld_r <= 1'b0;
      end
      if (wrEn) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------- configuration registers
  logic [31:0] mrg;
  assign mrg = strbMerge(32'h0000_0000, wData_r, wStrb_r);

  always_ff @(posedge clock) begin
    if (rst) begin
      totalSec_r <= 32'h0000_0000;
      defCyl_r   <= 16'h0000;
      defHeads_r <= 16'h0000;
      defSpt_r   <= 16'h0000;
      maxMult_r  <= `IPB_RST_MAXMULT;
      curCyl_r   <= 16'h0000;
      curHeads_r <= 16'h0000;
      curSpt_r   <= 16'h0000;
    end else begin
      if (wrHit(`IPB_OFF_TOTAL)) begin
        totalSec_r <= strbMerge(totalSec_r, wData_r, wStrb_r);
      end
      if (wrHit(`IPB_OFF_DEFGEO)) begin
        {defHeads_r, defCyl_r} <=
          strbMerge({defHeads_r, defCyl_r}, wData_r, wStrb_r);
      end
      if (wrHit(`IPB_OFF_DEFSPT)) begin
        {maxMult_r, defSpt_r} <= 24'(
          strbMerge({8'h00, maxMult_r, defSpt_r}, wData_r, wStrb_r));
      end
      if (wrHit(`IPB_OFF_CURGEO)) begin
        {curHeads_r, curCyl_r} <=
          strbMerge({curHeads_r, curCyl_r}, wData_r, wStrb_r);
      end
      if (wrHit(`IPB_OFF_CURSPT)) begin
        curSpt_r <= 16'(strbMerge({16'h0000, curSpt_r}, wData_r, wStrb_r));
      end
    end
  end

  // multiple sector setting is clamped to zero or one
  always_ff @(posedge clock) begin
    if (rst) begin
      mult_r <= 8'h00;
    end else if (wrHit(`IPB_OFF_CURSPT) && wStrb_r[2]) begin
      mult_r <= (wData_r[23:16] != 8'h00) ? 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cap_r     <= `IPB_RST_CAP;
      mdmaSup_r <= `IPB_RST_MDMASUP;
      mdmaSel_r <= ipb_pkg::IPB_MDMA_NONE;
      pioSup_r  <= `IPB_RST_PIOSUP;
    end else if (wrHit(`IPB_OFF_MODE)) begin
      if (wStrb_r[0]) begin
        cap_r     <= mrg[3:0];
        mdmaSup_r <= mrg[6:4];
      end
      if (wStrb_r[1]) begin
        mdmaSel_r <= ipb_pkg::ipb_mdma_e'(mrg[9:8]);
        pioSup_r  <= mrg[13:12];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dmaMin_r  <= `IPB_RST_TIME;
      dmaRec_r  <= `IPB_RST_TIME;
      pioNoFc_r <= `IPB_RST_TIME;
    end else begin
      if (wrHit(`IPB_OFF_DMATIME)) begin
        {dmaRec_r, dmaMin_r} <=
          strbMerge({dmaRec_r, dmaMin_r}, wData_r, wStrb_r);
      end
      if (wrHit(`IPB_OFF_PIOTIME)) begin
        pioNoFc_r <= 16'(strbMerge({16'h0000, pioNoFc_r}, wData_r, wStrb_r));
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sataCap_r  <= `IPB_RST_SATACAP;
      sataFeat_r <= `IPB_RST_SATAFT;
    end else if (wrHit(`IPB_OFF_SATA)) begin
      sataCap_r  <= {mrg[10:8], 5'h00, mrg[2:1], 1'b0};
      sataFeat_r <= {mrg[22:17], 1'b0};
    end
  end

  // character store; lengths are clamped to the field sizes
  always_ff @(posedge clock) begin
    if (rst) begin
      serLen_r <= 5'h00;
      modLen_r <= 6'h00;
      winIdx_r <= 8'h00;
    end else begin
      if (wrHit(`IPB_OFF_STRLEN)) begin
        serLen_r <= (mrg[4:0] > `IPB_SER_LEN) ? `IPB_SER_LEN : mrg[4:0];
        modLen_r <= (mrg[13:8] > `IPB_MOD_LEN) ? `IPB_MOD_LEN : mrg[13:8];
      end
      if (wrHit(`IPB_OFF_WINDEX)) begin
        winIdx_r <= mrg[7:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 20; i++) begin
        serChars[i] <= `IPB_PAD_CHAR;
      end
      for (int i = 0; i < 40; i++) begin
        modChars[i] <= `IPB_PAD_CHAR;
      end
    end else if (wrHit(`IPB_OFF_CHAR) && wStrb_r[0]) begin
      if (!wData_r[16] && wData_r[13:8] < 6'd20) begin
        serChars[wData_r[12:8]] <= wData_r[7:0];
      end else if (wData_r[16] && wData_r[13:8] < 6'd40) begin
        modChars[wData_r[13:8]] <= wData_r[7:0];
      end
    end
  end

  // ---------------- axi4-lite read channels
  logic [31:0] rdMux;
  logic        rdOk;

  always_comb begin
    rdOk  = 1'b1;
    rdMux = 32'h0000_0000;
    unique case ({s_axi_araddr[7:2], 2'b00})
      `IPB_OFF_TOTAL:   rdMux = totalSec_r;
      `IPB_OFF_DEFGEO:  rdMux = {defHeads_r, defCyl_r};
      `IPB_OFF_DEFSPT:  rdMux = {8'h00, maxMult_r, defSpt_r};
      `IPB_OFF_CURGEO:  rdMux = {curHeads_r, curCyl_r};
      `IPB_OFF_CURSPT:  rdMux = {8'h00, mult_r, curSpt_r};
      `IPB_OFF_MODE:    rdMux = {18'h00000, pioSup_r, 2'h0, mdmaSel_r,
                                 1'b0, mdmaSup_r, cap_r};
      `IPB_OFF_DMATIME: rdMux = {dmaRec_r, dmaMin_r};
      `IPB_OFF_PIOTIME: rdMux = {16'h0000, pioNoFc_r};
      `IPB_OFF_SATA:    rdMux = {9'h000, sataFeat_r[6:1], 6'h00, sataCap_r};
      `IPB_OFF_CHAR:    rdMux = 32'h0000_0000;
      `IPB_OFF_STRLEN:  rdMux = {18'h00000, modLen_r, 3'h0, serLen_r};
      `IPB_OFF_STATUS:  rdMux = {13'h0000, (w67 != pioNoFc_r),
                                 (w66 != dmaRec_r), (w65 != dmaMin_r),
                                 reqCount_r};
      `IPB_OFF_WINDEX:  rdMux = {24'h000000, winIdx_r};
      `IPB_OFF_WDATA:   rdMux = {16'h0000, identWord(winIdx_r)};
      default:          rdOk  = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= rdOk ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- assertions
  AST_TOTAL_LSW: assert property (@(posedge clock) disable iff (rst)
    wordReqValid && wordReqIndex == 8'd7 |=>
      wordValid && wordData == $past(totalSec_r[15:0]))
    else $error("word 7 does not carry the total sector count");

  AST_SERIAL_PAD: assert property (@(posedge clock) disable iff (rst)
    wordReqValid && wordReqIndex == 8'd10 && serLen_r <= 5'd18 |=>
      wordData == 16'h2020)
    else $error("serial field not padded on the left");

  AST_MODEL_PAD: assert property (@(posedge clock) disable iff (rst)
    wordReqValid && wordReqIndex == 8'd46 && modLen_r <= 6'd38 |=>
      wordData == 16'h2020)
    else $error("model field not padded on the right");

  AST_CAP_BITS: assert property (@(posedge clock) disable iff (rst)
    wordReqValid && wordReqIndex == 8'd49 |=>
      wordData[13] == 1'b0 && wordData[11:8] == $past(cap_r))
    else $error("capabilities word wrong");

  AST_VALID_53: assert property (@(posedge clock) disable iff (rst)
    wordReqValid && wordReqIndex == 8'd53 |=> wordData == 16'h0007)
    else $error("field validity word wrong");

  AST_MULT_59: assert property (@(posedge clock) disable iff (rst)
    wordReqValid && wordReqIndex == 8'd59 |=>
      wordData[15:8] == 8'h01 && wordData[7:0] <= 8'h01)
    else $error("multiple sector setting word wrong");

  AST_DMA_ONEHOT: assert property (@(posedge clock) disable iff (rst)
    $onehot0(mdmaOneHot) && mdmaOneHot[7:3] == 5'h00)
    else $error("more than one dma mode selected");

  AST_DMA_FLOOR: assert property (@(posedge clock) disable iff (rst)
    mdmaSup_r != 3'h0 |-> w65 >= dmaFloor && w66 >= w65)
    else $error("dma cycle times out of order");

  AST_PIO_ORDER: assert property (@(posedge clock) disable iff (rst)
    pioSup_r[1] |-> w68 == 16'h0078 && w67 >= w68)
    else $error("pio cycle times out of order");

  AST_UNSUP_ZERO: assert property (@(posedge clock) disable iff (rst)
    wordReqValid && wordReqIndex == 8'd65 && mdmaSup_r == 3'h0 |=>
      wordData == 16'h0000)
    else $error("unsupported cycle field not zero");

  AST_WORD0: assert property (@(posedge clock) disable iff (rst)
    wordReqValid && wordReqIndex == 8'd0 |=> wordData == 16'h045a)
    else $error("general configuration word wrong");

  AST_RESERVED: assert property (@(posedge clock) disable iff (rst)
    wordReqValid && wordReqIndex == 8'd70 ##1 !wordReqValid |=>
      $stable(wordData) && wordData == 16'h0000)
    else $error("reserved word not zero");

endmodule // ipb_identify_block

// >>> design/ipb_params.svh
`ifndef IPB_PARAMS_SVH
`define IPB_PARAMS_SVH

// register byte offsets on the axi4-lite bus
`define IPB_OFF_TOTAL   8'h00
`define IPB_OFF_DEFGEO  8'h04
`define IPB_OFF_DEFSPT  8'h08
`define IPB_OFF_CURGEO  8'h0c
`define IPB_OFF_CURSPT  8'h10
`define IPB_OFF_MODE    8'h14
`define IPB_OFF_DMATIME 8'h18
`define IPB_OFF_PIOTIME 8'h1c
`define IPB_OFF_SATA    8'h20
`define IPB_OFF_CHAR    8'h24
`define IPB_OFF_STRLEN  8'h28
`define IPB_OFF_STATUS  8'h2c
`define IPB_OFF_WINDEX  8'h30
`define IPB_OFF_WDATA   8'h34

// identify fixed words, pad character and field lengths
`define IPB_WORD0_VAL   16'h045a
`define IPB_WORD50_VAL  16'h4000
`define IPB_WORD51_VAL  16'h0200
`define IPB_WORD53_VAL  16'h0007
`define IPB_WORD47_HI   8'h80
`define IPB_PAD_CHAR    8'h20
`define IPB_SER_LEN     5'd20
`define IPB_MOD_LEN     6'd40

// reset values of the writable fields
`define IPB_RST_CAP     4'hf
`define IPB_RST_MDMASUP 3'h7
`define IPB_RST_PIOSUP  2'h3
`define IPB_RST_TIME    16'h0078
`define IPB_RST_MAXMULT 8'h01
`define IPB_RST_SATACAP 11'h006
`define IPB_RST_SATAFT  7'h08

// cycle times in ns of the fastest modes
`define IPB_MDMA0_NS    16'h01e0
`define IPB_MDMA1_NS    16'h0096
`define IPB_MDMA2_NS    16'h0078
`define IPB_PIO3_NS     16'h00b4
`define IPB_PIO4_NS     16'h0078

`endif

// >>> design/ipb_pkg.sv
package ipb_pkg;
  typedef logic [15:0] ipb_word_t;
  typedef logic [7:0]  ipb_char_t;
  // selected multiword dma mode, none or mode 0..2
  typedef enum logic [1:0] {
    IPB_MDMA_NONE,
    IPB_MDMA_0,
    IPB_MDMA_1,
    IPB_MDMA_2
  } ipb_mdma_e;
endpackage

// >>> dv/ipb_host_model.sv
`timescale 1ns/1ps
module ipb_host_model (
  input  wire logic       clock,        // core clock
  output logic            wordReqValid, // word request
  output logic [7:0]      wordReqIndex  // requested word number
);
  initial begin
    wordReqValid = 1'b0;
    wordReqIndex = 8'h00;
  end

  // n consecutive words, one request per cycle
  task automatic read_run(input int first, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clock);
      wordReqValid <= 1'b1;
      wordReqIndex <= 8'(first + k);
    end
    @(posedge clock);
    wordReqValid <= 1'b0;
    // a released index must not look like the last one
    wordReqIndex <= ~8'(first + n - 1);
  endtask
endmodule // ipb_host_model

// >>> dv/ipb_identify_block_bench.sv
`timescale 1ns/1ps
`include "ipb_params.svh"
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end

module ipb_identify_block_bench;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        wordReqValid, wordValid;
  logic [7:0]  wordReqIndex;
  logic [15:0] wordData, ew;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, tot, cyl, hd, spt, prod;
  logic [3:0]  s_axi_wstrb = 4'hf, c;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_rvalid, s_axi_bvalid;
  logic        s_axi_awready, s_axi_wready, s_axi_arready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] ea;
  logic [15:0] wordQ[$];
  logic [33:0] axiQ[$];
  int          error_cnt = 0, comparisons = 0;
  int          ri[20] = '{0, 3, 47, 49, 50, 51, 53, 59, 63, 64, 65, 66, 67,
                          68, 76, 78, 62, 200, 10, 27};
  logic [15:0] rv[20] = '{16'h045a, 16'h0000, 16'h8001, 16'h0f00, 16'h4000,
    16'h0200, 16'h0007, 16'h0100, 16'h0007, 16'h0003, 16'h0078, 16'h0078,
    16'h0078, 16'h0078, 16'h0006, 16'h0008, 16'h0000, 16'h0000, 16'h2020,
    16'h2020};

  always #12.5 clock = ~clock;

  ipb_identify_block i_dut (.clock, .rst, .wordReqValid, .wordReqIndex,
    .wordValid, .wordData, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  ipb_host_model i_host (.clock, .wordReqValid, .wordReqIndex);

  // answers are matched against the oldest expectation
  always @(negedge clock) begin
    if (wordValid === 1'b1) begin
      ew = (wordQ.size() > 0) ? wordQ.pop_front() : 16'hxxxx;
      `CHK(wordData, ew)
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      `CHK(s_axi_bresp, 2'b00)
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      ea = (axiQ.size() > 0) ? axiQ.pop_front() : 34'hx;
      `CHK({s_axi_rresp, s_axi_rdata}, ea)
    end
  end

  task automatic end_of_test();
    if (wordQ.size() != 0 || axiQ.size() != 0) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=0", $time,
               wordQ.size() + axiQ.size());
    end
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tmo();
    error_cnt++;
    $display("ERROR t=%0t got=0 exp=1 wait limit", $time);
    end_of_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w;
    int n;
    aw = 1;
    w = 1;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 40) begin
      @(posedge clock);
      n++;
      if (!aw && !w && s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        return;
      end
      if (aw && s_axi_awready === 1'b1) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    tmo();
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    axiQ.push_back(e);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 40) begin
      @(posedge clock);
      n++;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask

  task automatic ex(input int i, input logic [15:0] v);
    wordQ.push_back(v);
    i_host.read_run(i, 1);
  endtask

  initial begin
    void'($urandom(48));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (int k = 0; k < 20; k++)
      ex(ri[k], rv[k]);
    rd(`IPB_OFF_MODE, {2'b00, 32'h0000_307f});
    rd(8'h40, {2'b10, 32'h0});
    rd(`IPB_OFF_STATUS, {2'b00, 32'h0000_0014});
    $display("test reset values done");
    tot = $urandom();
    cyl = $urandom_range(1000, 1);
    hd = $urandom_range(16, 1);
    spt = $urandom_range(63, 1);
    prod = cyl * hd * spt;
    wr(`IPB_OFF_TOTAL, tot);
    wr(`IPB_OFF_DEFGEO, {hd[15:0], 16'h0007});
    wr(`IPB_OFF_DEFSPT, {16'h0010, spt[15:0]});
    wr(`IPB_OFF_CURGEO, {hd[15:0], cyl[15:0]});
    wr(`IPB_OFF_CURSPT, {16'h0005, spt[15:0]});
    ex(7, tot[15:0]);
    ex(8, tot[31:16]);
    ex(60, tot[15:0]);
    ex(61, tot[31:16]);
    ex(3, hd[15:0]);
    ex(6, spt[15:0]);
    ex(54, cyl[15:0]);
    ex(55, hd[15:0]);
    ex(1, 16'h0007);
    ex(56, spt[15:0]);
    ex(57, prod[15:0]);
    ex(58, prod[31:16]);
    ex(47, 16'h8010);
    ex(59, 16'h0101);
    // low two byte lanes only: the multiple setting must survive
    s_axi_wstrb <= 4'h3;
    wr(`IPB_OFF_CURSPT, 32'h0000_0009);
    s_axi_wstrb <= 4'hf;
    ex(56, 16'h0009);
    ex(59, 16'h0101);
    $display("test geometry done");
    wr(`IPB_OFF_CHAR, 32'h0000_0041);
    wr(`IPB_OFF_CHAR, 32'h0000_0142);
    wr(`IPB_OFF_CHAR, 32'h0001_0058);
    wr(`IPB_OFF_CHAR, 32'h0001_0159);
    wr(`IPB_OFF_CHAR, 32'h0001_025a);
    wr(`IPB_OFF_STRLEN, 32'h0000_0302);
    repeat (9) wordQ.push_back(16'h2020);
    wordQ.push_back(16'h4142);
    i_host.read_run(10, 10);
    ex(27, 16'h5859);
    ex(28, 16'h5a20);
    ex(46, 16'h2020);
    $display("test strings done");
    for (int s = 0; s < 4; s++) begin
      c = 4'($urandom());
      wr(`IPB_OFF_MODE, 32'h0000_3070 | (32'(s) << 8) | 32'(c));
      ex(63, 16'h0007 | (s > 0 ? 16'h0080 << s : 16'h0000));
      ex(49, {4'h0, c, 8'h00});
    end
    wr(`IPB_OFF_DMATIME, 32'h0300_0010);
    wr(`IPB_OFF_PIOTIME, 32'h0000_0200);
    wr(`IPB_OFF_MODE, 32'h0000_101f);
    ex(63, 16'h0001);
    ex(65, 16'h01e0);
    ex(66, 16'h0300);
    ex(64, 16'h0001);
    ex(68, 16'h00b4);
    ex(67, 16'h0200);
    wr(`IPB_OFF_DMATIME, 32'h0020_0010);
    wr(`IPB_OFF_PIOTIME, 32'h0000_0010);
    wr(`IPB_OFF_MODE, 32'h0000_203f);
    ex(65, 16'h0096);
    ex(66, 16'h0096);
    ex(64, 16'h0002);
    ex(68, 16'h0078);
    ex(67, 16'h0078);
    wr(`IPB_OFF_MODE, 32'h0000_000f);
    for (int k = 63; k < 69; k++)
      ex(k, 16'h0000);
    ex(70, 16'h0000);
    $display("test transfer modes done");
    wr(`IPB_OFF_SATA, 32'hffff_ffff);
    ex(76, 16'h0706);
    ex(78, 16'h007e);
    wr(`IPB_OFF_WINDEX, 32'h0000_004c);
    rd(`IPB_OFF_WDATA, {2'b00, 32'h0000_0706});
    $display("test serial link done");
    repeat (5) @(posedge clock);
    end_of_test();
  end
endmodule // ipb_identify_block_bench
